// file: logic/sra_map.svh
// Constants for the serial register access link: addresses, counts and timing.
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH
// Seven-bit slave identities for the eight select codes.
`define SRA_ID_DEF0 7'h10
`define SRA_ID_DEF1 7'h18
`define SRA_ID_DEF2 7'h36
`define SRA_ID_DEF3 7'h37
`define SRA_ID_DEF4 7'h20
`define SRA_ID_DEF5 7'h28
`define SRA_ID_FIX6 7'h30
`define SRA_ID_FIX7 7'h38
`define SRA_SEL_FIXED 3'h6
// Byte framing.
`define SRA_BITS_PER_BYTE 4'h8
`define SRA_DIR_READ 1'b1
`define SRA_IDX_DEV 2'h0
`define SRA_IDX_AHI 2'h1
`define SRA_IDX_ALO 2'h2
`define SRA_IDX_DATA 2'h3
// Host timing: four quarters make one serial clock period.
`define SRA_CLK_HZ 200000000
`define SRA_SCL_HZ 400000
`define SRA_QUARTER_CYC (`SRA_CLK_HZ / (4 * `SRA_SCL_HZ))
`endif

// file: logic/sra_pkg.sv
// Types shared by both ends of the serial register access link.
package sra_pkg;
   typedef logic [6:0]  sra_id_t;
   typedef logic [7:0]  sra_byte_t;
   typedef logic [15:0] sra_addr_t;
   typedef enum logic [5:0] {
      D_IDLE = 6'h01,
      D_RX   = 6'h02,
      D_ACK  = 6'h04,
      D_TX   = 6'h08,
      D_MACK = 6'h10,
      D_IGN  = 6'h20
   } sra_dev_state_t;
   typedef enum logic [5:0] {
      H_IDLE  = 6'h01,
      H_START = 6'h02,
      H_WBYTE = 6'h04,
      H_RBYTE = 6'h08,
      H_WAIT  = 6'h10,
      H_STOP  = 6'h20
   } sra_host_phase_t;
   typedef enum logic [4:0] {
      K_DEVW = 5'h01,
      K_AHI  = 5'h02,
      K_ALO  = 5'h04,
      K_DAT  = 5'h08,
      K_DEVR = 5'h10
   } sra_host_step_t;
endpackage

// file: logic/sra_link_if.sv
// Two-wire link between the bus master and the register access slave.
`timescale 1ns/10ps
interface sra_link_if;
   logic scl;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   logic sda;
   // The data line is open drain with a pull-up: any enabled low driver wins.
   assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
   modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
   modport slave  (input scl, input sda, output sda_s_out, output sda_s_oe);
endinterface

// file: logic/sra_host.sv
// Bus master end: makes the serial clock and runs write and read sequences.
`timescale 1ns/10ps
`include "sra_map.svh"
module sra_host #(
   parameter int QUARTER_CYC = `SRA_QUARTER_CYC
) (
   // Clock and reset.
   input  wire logic               clk_in,
   input  wire logic               arst_n_in,
   // Link.
   sra_link_if.master              link,
   // Command.
   input  wire logic               cmd_valid_in,
   output logic                    cmd_ready_out,
   input  wire logic               cmd_read_in,
   input  wire logic               cmd_random_in,
   input  wire sra_pkg::sra_id_t   cmd_id_in,
   input  wire sra_pkg::sra_addr_t cmd_addr_in,
   input  wire sra_pkg::sra_byte_t cmd_len_in,
   // Write data.
   input  wire logic               wr_valid_in,
   output logic                    wr_ready_out,
   input  wire sra_pkg::sra_byte_t wr_data_in,
   // Read data and status.
   output logic                    rd_valid_out,
   output sra_pkg::sra_byte_t      rd_data_out,
   output logic                    done_out,
   output logic                    nack_out
);
   import sra_pkg::*;

   sra_host_phase_t phase, next_phase;
   sra_host_step_t  step, next_step;
   logic [15:0]     qdiv, next_qdiv;
   logic [1:0]      q, next_q;
   logic [3:0]      bitn, next_bitn;
   sra_byte_t       shreg, next_shreg;
   sra_byte_t       len, next_len;
   logic            rnd_read, next_rnd_read;
   sra_id_t         id, next_id;
   sra_addr_t       addr, next_addr;
   logic            acked, next_acked;
   logic            scl, next_scl;
   logic            sda_oe, next_sda_oe;
   logic            rd_valid, next_rd_valid;
   sra_byte_t       rd_data, next_rd_data;
   logic            done, next_done;
   logic            nack, next_nack;
   logic            sda_meta;
   logic            sda_sync;
   logic            tick;
   logic            slot_end;
   logic            running;

   assign running  = (phase != H_IDLE) && (phase != H_WAIT);
   assign tick     = running && (qdiv == 16'(QUARTER_CYC - 1));
   assign slot_end = tick && (q == 2'h3);

   always_comb begin
      next_phase    = phase;
      next_step     = step;
      next_qdiv     = tick ? 16'h0000 : (running ? qdiv + 16'h0001 : 16'h0000);
      next_q        = tick ? q + 2'h1 : q;
      next_bitn     = bitn;
      next_shreg    = shreg;
      next_len      = len;
      next_rnd_read = rnd_read;
      next_id       = id;
      next_addr     = addr;
      next_acked    = acked;
      next_rd_valid = 1'b0;
      next_rd_data  = rd_data;
      next_done     = 1'b0;
      next_nack     = nack;
      unique case (phase)
         H_IDLE: begin
            next_q = 2'h0;
            if (cmd_valid_in) begin
               next_id       = cmd_id_in;
               next_addr     = cmd_addr_in;
               next_len      = (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
               next_rnd_read = cmd_read_in && cmd_random_in;
               next_nack     = 1'b0;
               next_step     = (cmd_read_in && !cmd_random_in) ? K_DEVR : K_DEVW;
               next_phase    = H_START;
            end
         end
         H_WAIT: begin
            if (wr_valid_in) begin
               next_shreg = wr_data_in;
               next_bitn  = 4'h0;
               next_phase = H_WBYTE;
            end
         end
         H_START: begin
            if (slot_end) begin
               next_shreg = {id, step == K_DEVR};
               next_bitn  = 4'h0;
               next_phase = H_WBYTE;
            end
         end
         H_WBYTE: begin
            if (tick && q == 2'h1 && bitn == `SRA_BITS_PER_BYTE) begin
               next_acked = !sda_sync;
            end
            if (slot_end && bitn != `SRA_BITS_PER_BYTE) begin
               next_bitn  = bitn + 4'h1;
               next_shreg = {shreg[6:0], 1'b0};
            end else if (slot_end) begin
               next_bitn = 4'h0;
               if (!acked) begin
                  next_nack  = 1'b1;
                  next_phase = H_STOP;
               end else begin
                  unique case (step)
                     K_DEVW: begin
                        next_step  = K_AHI;
                        next_shreg = addr[15:8];
                     end
                     K_AHI: begin
                        next_step  = K_ALO;
                        next_shreg = addr[7:0];
                     end
                     K_ALO: begin
                        // A random read turns the address write into a repeated start.
                        next_step  = rnd_read ? K_DEVR : K_DAT;
                        next_phase = rnd_read ? H_START : H_WAIT;
                     end
                     K_DAT: begin
                        next_len   = len - 8'h01;
                        next_phase = (len == 8'h01) ? H_STOP : H_WAIT;
                     end
                     K_DEVR: begin
                        next_phase = H_RBYTE;
                     end
                  endcase
               end
            end
         end
         H_RBYTE: begin
            if (tick && q == 2'h1 && bitn != `SRA_BITS_PER_BYTE) begin
               next_shreg = {shreg[6:0], sda_sync};
            end
            if (slot_end && bitn != `SRA_BITS_PER_BYTE) begin
               next_bitn = bitn + 4'h1;
            end else if (slot_end) begin
               next_bitn     = 4'h0;
               next_rd_valid = 1'b1;
               next_rd_data  = shreg;
               next_len      = len - 8'h01;
               next_phase    = (len == 8'h01) ? H_STOP : H_RBYTE;
            end
         end
         H_STOP: begin
            if (slot_end) begin
               next_done  = 1'b1;
               next_phase = H_IDLE;
            end
         end
         default: next_phase = H_IDLE;
      endcase
   end

   // Pin levels follow the slot and quarter; they are registered one cycle later.
   always_comb begin
      next_scl    = (q == 2'h1) || (q == 2'h2);
      next_sda_oe = 1'b0;
      unique case (phase)
         H_IDLE:  next_scl = 1'b1;
         H_WAIT:  next_scl = 1'b0;
         H_START: next_sda_oe = q[1];
         H_STOP: begin
            next_scl    = (q != 2'h0);
            next_sda_oe = !q[1];
         end
         H_WBYTE: next_sda_oe = (bitn != `SRA_BITS_PER_BYTE) && !shreg[7];
         // Every byte but the last is acknowledged; the last gets a no-acknowledge.
         H_RBYTE: next_sda_oe = (bitn == `SRA_BITS_PER_BYTE) && (len != 8'h01);
         default: next_scl = 1'b1;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase    <= H_IDLE;
         step     <= K_DEVW;
         qdiv     <= 16'h0000;
         q        <= 2'h0;
         bitn     <= 4'h0;
         shreg    <= 8'h00;
         len      <= 8'h00;
         rnd_read <= 1'b0;
         id       <= 7'h00;
         addr     <= 16'h0000;
         acked    <= 1'b0;
         scl      <= 1'b1;
         sda_oe   <= 1'b0;
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
         done     <= 1'b0;
         nack     <= 1'b0;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         phase    <= next_phase;
         step     <= next_step;
         qdiv     <= next_qdiv;
         q        <= next_q;
         bitn     <= next_bitn;
         shreg    <= next_shreg;
         len      <= next_len;
         rnd_read <= next_rnd_read;
         id       <= next_id;
         addr     <= next_addr;
         acked    <= next_acked;
         scl      <= next_scl;
         sda_oe   <= next_sda_oe;
         rd_valid <= next_rd_valid;
         rd_data  <= next_rd_data;
         done     <= next_done;
         nack     <= next_nack;
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
      end
   end

   assign link.scl      = scl;
   assign link.sda_m_out = 1'b0;
   assign link.sda_m_oe = sda_oe;
   assign cmd_ready_out = (phase == H_IDLE);
   assign wr_ready_out  = (phase == H_WAIT);
   assign rd_valid_out  = rd_valid;
   assign rd_data_out   = rd_data;
   assign done_out      = done;
   assign nack_out      = nack;
endmodule

// file: logic/sra_dev.sv
// Register access slave: the sensor end of the two-wire link.
`timescale 1ns/10ps
`include "sra_map.svh"
module sra_dev (
   // Clock and reset; the link is oversampled on the master input clock.
   input  wire logic                   master_input_clock_in,
   input  wire logic                   arst_n_in,
   // Link.
   sra_link_if.slave                   link,
   // Slave address selection.
   input  wire logic [2:0]             slave_id_select_in,
   input  wire logic [5:0][6:0]        prog_id_in,
   // Register file access.
   output sra_pkg::sra_addr_t          reg_addr_out,
   output sra_pkg::sra_byte_t          reg_wdata_out,
   output logic                        reg_wr_out,
   output logic                        reg_rd_out,
   input  wire sra_pkg::sra_byte_t     reg_rdata_in,
   // Status.
   output logic                        busy_out
);
   import sra_pkg::*;

   // Synchronisers.
   logic           scl_meta;
   logic           scl_sync;
   logic           scl_prev;
   logic           sda_meta;
   logic           sda_sync;
   logic           sda_prev;
   logic [2:0]     sel_meta;
   logic [2:0]     sel_sync;

   // Protocol state.
   sra_dev_state_t state, next_state;
   logic [3:0]     bit_cnt, next_bit_cnt;
   logic [1:0]     byte_idx, next_byte_idx;
   sra_byte_t      shreg, next_shreg;
   sra_addr_t      ptr, next_ptr;
   logic           rw_read, next_rw_read;
   logic           sda_drive, next_sda_drive;
   logic           mack_ok, next_mack_ok;
   sra_addr_t      reg_addr, next_reg_addr;
   sra_byte_t      reg_wdata, next_reg_wdata;
   logic           reg_wr, next_reg_wr;
   logic           reg_rd, next_reg_rd;

   // Events and decode.
   logic           scl_rise;
   logic           scl_fall;
   logic           start_ev;
   logic           stop_ev;
   logic           byte_done;
   logic           load_tx;
   sra_id_t        own_id;

   // Pins come from another domain, so each passes two flops before use.
   always_ff @(posedge master_input_clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
         sel_meta <= 3'h0;
         sel_sync <= 3'h0;
      end else begin
         scl_meta <= link.scl;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
         sel_meta <= slave_id_select_in;
         sel_sync <= sel_meta;
      end
   end

   assign scl_rise  = scl_sync && !scl_prev;
   assign scl_fall  = !scl_sync && scl_prev;
   assign start_ev  = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign stop_ev   = scl_sync && scl_prev && !sda_prev && sda_sync;
   assign byte_done = scl_fall && (bit_cnt == `SRA_BITS_PER_BYTE);

   // The two top codes are fixed; the other six come from the register file.
   always_comb begin
      if (sel_sync >= `SRA_SEL_FIXED) begin
         own_id = sel_sync[0] ? `SRA_ID_FIX7 : `SRA_ID_FIX6;
      end else begin
         own_id = prog_id_in[sel_sync];
      end
   end

   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_byte_idx  = byte_idx;
      next_shreg     = shreg;
      next_ptr       = ptr;
      next_rw_read   = rw_read;
      next_sda_drive = sda_drive;
      next_mack_ok   = mack_ok;
      next_reg_addr  = ptr;
      next_reg_wdata = reg_wdata;
      next_reg_wr    = 1'b0;
      next_reg_rd    = 1'b0;
      load_tx        = 1'b0;
      if (stop_ev) begin
         next_state     = D_IDLE;
         next_sda_drive = 1'b0;
      end else if (start_ev) begin
         // A repeated start ends any transfer in progress just like a stop.
         next_state     = D_RX;
         next_bit_cnt   = 4'h0;
         next_byte_idx  = `SRA_IDX_DEV;
         next_sda_drive = 1'b0;
      end else begin
         unique case (state)
            D_IDLE: next_sda_drive = 1'b0;
            D_IGN:  next_sda_drive = 1'b0;
            D_RX: begin
               if (scl_rise) begin
                  next_shreg   = {shreg[6:0], sda_sync};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (byte_done) begin
                  next_bit_cnt   = 4'h0;
                  next_sda_drive = 1'b1;
                  next_state     = D_ACK;
                  if (byte_idx != `SRA_IDX_DATA) begin
                     next_byte_idx = byte_idx + 2'h1;
                  end
                  unique case (byte_idx)
                     `SRA_IDX_DEV: begin
                        next_rw_read = (shreg[0] == `SRA_DIR_READ);
                        if (shreg[7:1] != own_id) begin
                           next_sda_drive = 1'b0;
                           next_state     = D_IGN;
                        end
                     end
                     `SRA_IDX_AHI: next_ptr[15:8] = shreg;
                     `SRA_IDX_ALO: next_ptr[7:0] = shreg;
                     `SRA_IDX_DATA: begin
                        next_reg_wdata = shreg;
                        next_reg_wr    = 1'b1;
                        next_ptr       = ptr + 16'h0001;
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  next_sda_drive = 1'b0;
                  if (rw_read) begin
                     load_tx = 1'b1;
                  end else begin
                     next_state = D_RX;
                  end
               end
            end
            D_TX: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (byte_done) begin
                  next_sda_drive = 1'b0;
                  next_ptr       = ptr + 16'h0001;
                  next_state     = D_MACK;
               end else if (scl_fall) begin
                  next_shreg     = {shreg[6:0], 1'b0};
                  next_sda_drive = !shreg[6];
               end
            end
            D_MACK: begin
               if (scl_rise) begin
                  next_mack_ok = !sda_sync;
               end else if (scl_fall) begin
                  if (mack_ok) begin
                     load_tx = 1'b1;
                  end else begin
                     next_state = D_IGN;
                  end
               end
            end
            default: begin
               next_state     = D_IDLE;
               next_sda_drive = 1'b0;
            end
         endcase
         // Read data is taken at the clock fall that opens the byte, MSB first.
         if (load_tx) begin
            next_shreg     = reg_rdata_in;
            next_reg_rd    = 1'b1;
            next_bit_cnt   = 4'h0;
            next_sda_drive = !reg_rdata_in[7];
            next_state     = D_TX;
         end
      end
   end

   always_ff @(posedge master_input_clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state     <= D_IDLE;
         bit_cnt   <= 4'h0;
         byte_idx  <= 2'h0;
         shreg     <= 8'h00;
         ptr       <= 16'h0000;
         rw_read   <= 1'b0;
         sda_drive <= 1'b0;
         mack_ok   <= 1'b0;
         reg_addr  <= 16'h0000;
         reg_wdata <= 8'h00;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
      end else begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         byte_idx  <= next_byte_idx;
         shreg     <= next_shreg;
         ptr       <= next_ptr;
         rw_read   <= next_rw_read;
         sda_drive <= next_sda_drive;
         mack_ok   <= next_mack_ok;
         reg_addr  <= next_reg_addr;
         reg_wdata <= next_reg_wdata;
         reg_wr    <= next_reg_wr;
         reg_rd    <= next_reg_rd;
      end
   end

   // The data line is only ever pulled low; the clock has no driver here.
   assign link.sda_s_out = 1'b0;
   assign link.sda_s_oe  = sda_drive;
   assign reg_addr_out   = reg_addr;
   assign reg_wdata_out  = reg_wdata;
   assign reg_wr_out     = reg_wr;
   assign reg_rd_out     = reg_rd;
   assign busy_out       = (state != D_IDLE) && (state != D_IGN);
endmodule

// file: verif/sra_link_properties.sv
// Protocol checker for the slave's data-line drive on the two-wire link.
`timescale 1ns/10ps
module sra_link_properties (
   // Device clock domain.
   input  wire logic       master_input_clock_in,
   input  wire logic       arst_n_in,
   // Identity that the select inputs currently choose; changed only while the bus is idle.
   input  wire logic [6:0] own_id_in,
   // Link wires.
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic sda_s_out,
   input  wire logic sda_s_oe
);
   logic       scl_q, sda_q, first, matched, dir_rd, rise, start_c, stop_c;
   logic       next_first, next_matched, next_dir_rd;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   assign rise    = scl && !scl_q;
   assign start_c = scl && scl_q && sda_q && !sda;
   assign stop_c  = scl && scl_q && !sda_q && sda;
   // Bit 8 of each byte is the acknowledge slot; the id verdict is latched there.
   always_comb begin
      next_first   = first;
      next_matched = matched;
      next_dir_rd  = dir_rd;
      next_bit_cnt = bit_cnt;
      next_shreg   = shreg;
      if (start_c) begin
         next_bit_cnt = 4'h0;
         next_first   = 1'b1;
      end else if (rise) begin
         next_shreg   = {shreg[6:0], sda};
         next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
         if (bit_cnt == 4'h8 && first) begin
            next_first   = 1'b0;
            next_matched = (shreg[7:1] == own_id_in);
            next_dir_rd  = shreg[0];
         end
      end
   end
   always_ff @(posedge master_input_clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         {scl_q, sda_q, first, matched, dir_rd} <= 5'h1c;
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
      end else begin
         {scl_q, sda_q, first} <= {scl, sda, next_first};
         {matched, dir_rd}     <= {next_matched, next_dir_rd};
         bit_cnt <= next_bit_cnt;
         shreg   <= next_shreg;
      end
   end
   default clocking cb @(posedge master_input_clock_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_start; start_c; endsequence
   sequence s_stop; stop_c; endsequence
   sequence s_ack_slot; rise && bit_cnt == 4'h8; endsequence
   a_id_ack: assert property (s_ack_slot ##0 first |->
      sda_s_oe == (shreg[7:1] == own_id_in)) else $error("id acknowledge wrong");
   a_write_ack: assert property (s_ack_slot ##0 (!first && matched && !dir_rd)
      |-> sda_s_oe) else $error("write byte not acknowledged");
   a_read_ack_free: assert property (s_ack_slot ##0 (!first && matched && dir_rd)
      |-> !sda_s_oe) else $error("slave drives master acknowledge slot");
   a_ignore_other: assert property (!first && !matched |-> !sda_s_oe)
      else $error("unaddressed slave drives data line");
   a_start_quiet: assert property (s_start |=> (!sda_s_oe) [*8])
      else $error("slave drives after start");
   a_stop_quiet: assert property (s_stop |-> ##1 (!sda_s_oe) [*8])
      else $error("slave drives after stop");
   a_hold_high: assert property (scl && scl_q |-> $stable(sda_s_oe))
      else $error("slave drive changes while clock high");
   a_open_drain: assert property (sda_s_oe |-> !sda_s_out && !sda)
      else $error("slave drive does not pull line low");
endmodule

// file: verif/tb_serial_register_access_slave.sv
// Testbench joining the bus master and the register slave over the link.
`timescale 1ns/10ps
module tb_serial_register_access_slave;
   import sra_pkg::*;
   localparam sra_id_t ID = 7'h10;
   logic      clk_in = 1'b0, dclk = 1'b0, arst_n = 1'b0;
   logic      cv = 1'b0, crd = 1'b0, crnd = 1'b0, wv = 1'b0;
   logic      cr, wr_rdy, rv, done, nack, rwr, rrd, busy;
   logic [2:0] sel = 3'h0;
   sra_id_t   cid = '0, oid = ID;
   sra_addr_t caddr = '0, raddr;
   sra_byte_t clen = '0, rdat, rwd, wdat[4], mem[256];
   sra_addr_t wa[$];
   sra_byte_t rq[$];
   int        wi = 0, nrd = 0, mismatches = 0, tests_run = 0;
   sra_link_if i_sra_link_if ();
   // Shortest safe quarter keeps the run short against the 125 ns device clock.
   sra_host #(.QUARTER_CYC(100)) i_sra_host (.clk_in(clk_in), .arst_n_in(arst_n),
      .link(i_sra_link_if.master), .cmd_valid_in(cv), .cmd_ready_out(cr), .cmd_read_in(crd),
      .cmd_random_in(crnd), .cmd_id_in(cid), .cmd_addr_in(caddr), .cmd_len_in(clen),
      .wr_valid_in(wv), .wr_ready_out(wr_rdy), .wr_data_in(wdat[wi[1:0]]), .rd_valid_out(rv),
      .rd_data_out(rdat), .done_out(done), .nack_out(nack));
   sra_dev i_sra_dev (.master_input_clock_in(dclk), .arst_n_in(arst_n),
      .link(i_sra_link_if.slave), .slave_id_select_in(sel),
      .prog_id_in({7'h28, 7'h20, 7'h37, 7'h36, 7'h18, 7'h10}), .reg_addr_out(raddr),
      .reg_wdata_out(rwd), .reg_wr_out(rwr), .reg_rd_out(rrd), .reg_rdata_in(mem[raddr[7:0]]),
      .busy_out(busy));
   sra_link_properties i_sra_link_properties (.master_input_clock_in(dclk), .arst_n_in(arst_n),
      .own_id_in(oid), .scl(i_sra_link_if.scl), .sda(i_sra_link_if.sda),
      .sda_s_out(i_sra_link_if.sda_s_out),
      .sda_s_oe(i_sra_link_if.sda_s_oe));
   initial forever #2.5 clk_in = ~clk_in;
   initial begin
      #17;
      forever #62.5 dclk = ~dclk;
   end
   // Register strobes are taken mid-cycle, away from the edge that launches them.
   always @(negedge dclk) if (rwr === 1'b1) begin
      mem[raddr[7:0]] <= rwd;
      wa.push_back(raddr);
   end
   always @(negedge dclk) if (rrd === 1'b1) nrd++;
   always @(posedge clk_in) if (wv && wr_rdy === 1'b1) #1 wi = wi + 1;
   always @(negedge clk_in) if (rv === 1'b1) rq.push_back(rdat);
   function automatic sra_byte_t pat(input sra_byte_t i);
      return i ^ 8'h5a;
   endfunction
   task automatic note(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e); note(16'(g), 16'(e)); endtask
   task automatic chk_byte(input sra_byte_t g, input sra_byte_t e); note(16'(g), 16'(e)); endtask
   task automatic chk_addr(input sra_addr_t g, input sra_addr_t e); note(g, e); endtask
   task automatic run(input logic rd, input logic rnd, input sra_id_t id, input sra_addr_t a,
                      input sra_byte_t n);
      int k;
      rq.delete();
      wi = 0;
      nrd = 0;
      @(posedge clk_in);
      #1;
      chk_flag(cr, 1'b1);
      {cv, crd, crnd, cid, caddr, clen, wv} = {1'b1, rd, rnd, id, a, n, !rd};
      @(posedge clk_in);
      #1;
      cv = 1'b0;
      chk_flag(cr, 1'b0);
      k = 0;
      while (done !== 1'b1 && k < 30000) begin
         @(negedge clk_in);
         k++;
      end
      wv = 1'b0;
      if (k >= 30000) mismatches++;
   endtask
   task automatic t_write();
      wdat[0] = 8'ha1;
      wdat[1] = 8'hb2;
      run(1'b0, 1'b0, ID, 16'h3a7e, 8'h02);
      chk_flag(nack, 1'b0);
      chk_flag(busy, 1'b0);
      chk_addr(wa[0], 16'h3a7e);
      chk_addr(wa[1], 16'h3a7f);
      chk_byte(mem[8'h7e], 8'ha1);
      chk_byte(mem[8'h7f], 8'hb2);
      chk_byte(8'(nrd), 8'h00);
   endtask
   task automatic t_rand_read();
      run(1'b1, 1'b1, ID, 16'h3a7f, 8'h02);
      chk_byte(rq[0], 8'hb2);
      chk_byte(rq[1], pat(8'h80));
      chk_flag(nack, 1'b0);
      chk_byte(8'(nrd), 8'h02);
   endtask
   task automatic t_wrong_id();
      wdat[0] = 8'h77;
      run(1'b0, 1'b0, 7'h11, 16'h0005, 8'h01);
      chk_flag(nack, 1'b1);
      chk_byte(8'(wa.size()), 8'h02);
   endtask
   task automatic t_cur_read();
      run(1'b1, 1'b0, ID, 16'h0000, 8'h01);
      chk_byte(rq[0], pat(8'h81));
      chk_flag(busy, 1'b0);
      chk_byte(8'(nrd), 8'h01);
   endtask
   task automatic t_wrap();
      wdat[0] = 8'h5c;
      run(1'b0, 1'b0, ID, 16'hffff, 8'h01);
      chk_addr(wa[2], 16'hffff);
      chk_byte(mem[8'hff], 8'h5c);
      run(1'b1, 1'b0, ID, 16'h0000, 8'h01);
      chk_byte(rq[0], pat(8'h00));
   endtask
   // Select code 7 is a fixed identity; the pointer was left at 16'h0001.
   task automatic t_fixed_id();
      @(posedge clk_in);
      #1;
      sel = 3'h7;
      oid = 7'h38;
      repeat (4) @(posedge dclk);
      run(1'b1, 1'b0, 7'h38, 16'h0000, 8'h01);
      chk_flag(nack, 1'b0);
      chk_byte(rq[0], pat(8'h01));
      chk_byte(8'(nrd), 8'h01);
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = pat(8'(i));
      repeat (6) @(posedge dclk);
      #1;
      arst_n = 1'b1;
      t_write();
      t_rand_read();
      t_wrong_id();
      t_cur_read();
      t_wrap();
      t_fixed_id();
      complete_run();
   end
   // The whole sequence needs about 86000 cycles; this leaves some margin.
   initial begin
      repeat (95000) @(posedge clk_in);
      mismatches++;
      complete_run();
   end
endmodule
